// file: rtl/ssl_serial_latch.sv
// three-wire write port, latch decode and digital divider/lock logic of the synthesizer
//
// Function
// - gain bit one selects pump current setting two, zero selects setting one
// - setting one from low three-bit field, setting two from high field
// - with mute enabled, rf outputs stay off until lock is declared
// - pump high-impedance bit one three-states the charge pump
// - polarity bit one gives positive detector polarity, zero negative
// - three-bit select field chooses the multiplexed output pin source
// - counter reset bit holds reference and feedback counters in reset
// - two-bit core level and two-bit rf level fields drive outputs
// - five-bit swallow count loaded from feedback word, any value 0 to 31
// - thirteen-bit main count loaded from feedback word, valid 3 to 8191
// - feedback divides by prescaler modulus times main plus swallow
// - one gain bit, written by control or feedback word, latest wins
// - feedback bit 22 enables output divide-by-two
// - feedback bit 23 feeds divided output into the prescaler
// - address 01 loads reference latch with fourteen-bit divider 1 to 16383
// - antibacklash width from reference word bits 16 and 17
// - lock after five good cycles if precision one, else three
// - test latch always ignored; the factory test bit only sets the test mode flag
// - band select clock from reference output through programmable divider
// - 24 bits shifted on clock rises, committed when latch enable rises
// - address 00 loads the control latch
`timescale 1ns/10ps
`default_nettype none
`include "ssl_regs.svh"

module ssl_serial_latch #(
  parameter int unsigned WORD_BITS = `SSL_WORD_BITS
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  // three-wire write port
  input  wire logic        i_sclk,
  input  wire logic        i_sdata,
  input  wire logic        i_latch_enable,
  // loop events, one-cycle pulses
  input  wire logic        i_ref_tick,
  input  wire logic        i_fb_tick,
  input  wire logic        i_phase_ok,
  // decoded analog controls
  output logic [2:0]       o_pump_current,
  output logic             o_pump_hiz,
  output logic             o_detector_polarity,
  output logic [1:0]       o_core_level,
  output logic [1:0]       o_rf_level,
  output logic             o_rf_enable,
  output logic             o_out_div2,
  output logic             o_presc_from_div2,
  output logic [1:0]       o_antibacklash,
  output logic [1:0]       o_power_down,
  output logic             o_test_mode_active,
  // divider and lock outputs
  output logic             o_ref_div_pulse,
  output logic             o_fb_div_pulse,
  output logic             o_bsel_clk_pulse,
  output logic             o_lock,
  output logic             o_muxed_output_pin
);

  // =====================================================================
  // serial shift and latches
  // =====================================================================
  logic [WORD_BITS-1:0] shift_q, shift_d;
  logic [WORD_BITS-1:0] ctl_q, ctl_d;
  logic [WORD_BITS-1:0] fb_q, fb_d;
  logic [WORD_BITS-1:0] ref_q, ref_d;
  logic [WORD_BITS-1:0] test_q, test_d;
  logic                 gain_q, gain_d;
  logic                 sclk_q, latch_en_q;
  logic                 sclk_rise, latch_en_rise;
  ssl_pkg::ssl_target_type tgt;

  assign sclk_rise     = i_sclk & ~sclk_q;
  assign latch_en_rise = i_latch_enable & ~latch_en_q;
  assign tgt           = ssl_pkg::ssl_target_type'(shift_q[`SSL_ADDR_MSB:`SSL_ADDR_LSB]);

  // shift register keeps only the newest bits, so long frames still decode
  always_comb begin
    shift_d = shift_q;
    ctl_d   = ctl_q;
    fb_d    = fb_q;
    ref_d   = ref_q;
    test_d  = test_q;
    gain_d  = gain_q;
    if (sclk_rise) begin
      shift_d = {shift_q[WORD_BITS-2:0], i_sdata};
    end
    if (latch_en_rise) begin
      unique case (tgt)
        ssl_pkg::SSL_TGT_CONTROL: begin
          ctl_d  = shift_q;
          gain_d = shift_q[`SSL_CTL_GAIN];
        end
        ssl_pkg::SSL_TGT_REFERENCE: begin
          ref_d = shift_q;
        end
        ssl_pkg::SSL_TGT_FEEDBACK: begin
          fb_d   = shift_q;
          gain_d = shift_q[`SSL_FB_GAIN];
        end
        ssl_pkg::SSL_TGT_TEST: begin
          test_d = shift_q;
        end
      endcase
    end
  end

  // no reset pin on the real part; sync reset clears everything to zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shift_q <= '0;
      ctl_q   <= '0;
      fb_q    <= '0;
      ref_q   <= '0;
      test_q  <= '0;
      gain_q  <= 1'b0;
      sclk_q  <= 1'b0;
      latch_en_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      ctl_q   <= ctl_d;
      fb_q    <= fb_d;
      ref_q   <= ref_d;
      test_q  <= test_d;
      gain_q  <= gain_d;
      sclk_q  <= i_sclk;
      latch_en_q <= i_latch_enable;
    end
  end

  // =====================================================================
  // field decode
  // =====================================================================
  logic        cnt_rst;
  logic [4:0]  swallow;
  logic [12:0] main_cnt;
  logic [13:0] ref_div;
  logic [5:0]  presc;
  logic [17:0] fb_total;

  assign cnt_rst  = ctl_q[`SSL_CTL_CNT_RST];
  assign swallow  = fb_q[`SSL_FB_SWALLOW_MSB:`SSL_FB_SWALLOW_LSB];
  assign main_cnt = fb_q[`SSL_FB_MAIN_MSB:`SSL_FB_MAIN_LSB];
  assign ref_div  = ref_q[`SSL_REF_DIV_MSB:`SSL_REF_DIV_LSB];

  // prescaler modulus from the control word
  always_comb begin
    unique case (ctl_q[`SSL_CTL_PRESC_MSB:`SSL_CTL_PRESC_LSB])
      2'b00:   presc = `SSL_PRESC_P0;
      2'b01:   presc = `SSL_PRESC_P1;
      default: presc = `SSL_PRESC_P2;
    endcase
  end

  // total feedback ratio; 32 * 8191 + 31 fits in 18 bits
  assign fb_total = 18'(presc * main_cnt) + 18'(swallow);

  // pump current picks one of two programmed settings
  assign o_pump_current = gain_q ? ctl_q[`SSL_CTL_IHIGH_MSB:`SSL_CTL_IHIGH_LSB]
                                 : ctl_q[`SSL_CTL_ILOW_MSB:`SSL_CTL_ILOW_LSB];
  assign o_pump_hiz          = ctl_q[`SSL_CTL_PUMP_HIZ];
  assign o_detector_polarity = ctl_q[`SSL_CTL_POLARITY];
  assign o_core_level        = ctl_q[`SSL_CTL_CORE_MSB:`SSL_CTL_CORE_LSB];
  assign o_rf_level          = ctl_q[`SSL_CTL_RFLVL_MSB:`SSL_CTL_RFLVL_LSB];
  assign o_power_down        = ctl_q[`SSL_CTL_PDOWN_MSB:`SSL_CTL_PDOWN_LSB];
  assign o_out_div2          = fb_q[`SSL_FB_DIV2];
  assign o_presc_from_div2   = fb_q[`SSL_FB_DIV2_SEL];
  assign o_antibacklash      = ref_q[`SSL_REF_ABP_MSB:`SSL_REF_ABP_LSB];
  // test latch content never steers logic; only its enable is exposed
  assign o_test_mode_active  = ref_q[`SSL_REF_TEST];

  // =====================================================================
  // reference, feedback, band select dividers and lock detect
  // =====================================================================
  logic [13:0] rcnt_q, rcnt_d;
  logic [17:0] ncnt_q, ncnt_d;
  logic [2:0]  bcnt_q, bcnt_d;
  logic [2:0]  lcnt_q, lcnt_d;
  logic        lock_q, lock_d;
  logic        rpul_q, rpul_d;
  logic        npul_q, npul_d;
  logic        bpul_q, bpul_d;
  logic [2:0]  bsc_top;
  logic [2:0]  lock_need;

  // band select divide of 1, 2, 4 or 8 reference outputs
  always_comb begin
    unique case (ref_q[`SSL_REF_BSC_MSB:`SSL_REF_BSC_LSB])
      2'b00: bsc_top = 3'd0;
      2'b01: bsc_top = 3'd1;
      2'b10: bsc_top = 3'd3;
      2'b11: bsc_top = 3'd7;
    endcase
  end

  assign lock_need = ref_q[`SSL_REF_LOCK_PREC] ? `SSL_LOCK_CYC_FINE
                                               : `SSL_LOCK_CYC_COARSE;

  // counters run down from ratio-1; a zero ratio wraps to the full counter range
  always_comb begin
    rcnt_d = rcnt_q;
    ncnt_d = ncnt_q;
    bcnt_d = bcnt_q;
    lcnt_d = lcnt_q;
    lock_d = lock_q;
    rpul_d = 1'b0;
    npul_d = 1'b0;
    bpul_d = 1'b0;
    if (cnt_rst) begin
      rcnt_d = '0;
      ncnt_d = '0;
      bcnt_d = '0;
      lcnt_d = '0;
      lock_d = 1'b0;
    end else begin
      if (i_ref_tick) begin
        if (rcnt_q == 14'h0000) begin
          rcnt_d = ref_div - 14'h0001;
          rpul_d = 1'b1;
        end else begin
          rcnt_d = rcnt_q - 14'h0001;
        end
      end
      if (i_fb_tick) begin
        if (ncnt_q == 18'h0_0000) begin
          ncnt_d = fb_total - 18'h0_0001;
          npul_d = 1'b1;
        end else begin
          ncnt_d = ncnt_q - 18'h0_0001;
        end
      end
      // band select clock taken from reference output pulses
      if (rpul_q) begin
        if (bcnt_q >= bsc_top) begin
          bcnt_d = 3'd0;
          bpul_d = 1'b1;
        end else begin
          bcnt_d = bcnt_q + 3'd1;
        end
        // one phase check per reference cycle; a miss restarts the count
        if (!i_phase_ok) begin
          lcnt_d = 3'd0;
          lock_d = 1'b0;
        end else if (lcnt_q + 3'd1 >= lock_need) begin
          lcnt_d = lock_need;
          lock_d = 1'b1;
        end else begin
          lcnt_d = lcnt_q + 3'd1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rcnt_q <= '0;
      ncnt_q <= '0;
      bcnt_q <= '0;
      lcnt_q <= '0;
      lock_q <= 1'b0;
      rpul_q <= 1'b0;
      npul_q <= 1'b0;
      bpul_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      ncnt_q <= ncnt_d;
      bcnt_q <= bcnt_d;
      lcnt_q <= lcnt_d;
      lock_q <= lock_d;
      rpul_q <= rpul_d;
      npul_q <= npul_d;
      bpul_q <= bpul_d;
    end
  end

  assign o_ref_div_pulse  = rpul_q;
  assign o_fb_div_pulse   = npul_q;
  assign o_bsel_clk_pulse = bpul_q;
  assign o_lock           = lock_q;
  // mute holds the rf stage off until the loop reports lock
  assign o_rf_enable = ~(ctl_q[`SSL_CTL_MUTE] & ~lock_q);

  // =====================================================================
  // multiplexed output pin
  // =====================================================================
  logic mux_q, mux_d;

  always_comb begin
    unique case (ssl_pkg::ssl_outsel_type'(ctl_q[`SSL_CTL_OUTSEL_MSB:`SSL_CTL_OUTSEL_LSB]))
      ssl_pkg::SSL_MUX_LOW:    mux_d = 1'b0;
      ssl_pkg::SSL_MUX_LOCK:   mux_d = lock_q;
      ssl_pkg::SSL_MUX_FBDIV:  mux_d = npul_q;
      ssl_pkg::SSL_MUX_HIGH:   mux_d = 1'b1;
      ssl_pkg::SSL_MUX_REFDIV: mux_d = rpul_q;
      ssl_pkg::SSL_MUX_BSCLK:  mux_d = bpul_q;
      ssl_pkg::SSL_MUX_SDATA:  mux_d = shift_q[0];
      ssl_pkg::SSL_MUX_NLOCK:  mux_d = ~lock_q;
    endcase
  end

  // registered so the pin never glitches on select changes
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mux_q <= 1'b0;
    end else begin
      mux_q <= mux_d;
    end
  end

  assign o_muxed_output_pin = mux_q;

endmodule

`default_nettype wire

// file: include/ssl_regs.svh
// bit positions, field widths and fixed values of the three-wire latch words
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

`define SSL_WORD_BITS       24
// address bits at the bottom of every word
`define SSL_ADDR_LSB        0
`define SSL_ADDR_MSB        1
// loop_config_word fields
`define SSL_CTL_CORE_LSB    2
`define SSL_CTL_CORE_MSB    3
`define SSL_CTL_CNT_RST     4
`define SSL_CTL_OUTSEL_LSB  5
`define SSL_CTL_OUTSEL_MSB  7
`define SSL_CTL_POLARITY    8
`define SSL_CTL_PUMP_HIZ    9
`define SSL_CTL_GAIN        10
`define SSL_CTL_MUTE        11
`define SSL_CTL_RFLVL_LSB   12
`define SSL_CTL_RFLVL_MSB   13
`define SSL_CTL_ILOW_LSB    14
`define SSL_CTL_ILOW_MSB    16
`define SSL_CTL_IHIGH_LSB   17
`define SSL_CTL_IHIGH_MSB   19
`define SSL_CTL_PDOWN_LSB   20
`define SSL_CTL_PDOWN_MSB   21
`define SSL_CTL_PRESC_LSB   22
`define SSL_CTL_PRESC_MSB   23
// feedback_divider_word fields
`define SSL_FB_SWALLOW_LSB  2
`define SSL_FB_SWALLOW_MSB  6
`define SSL_FB_MAIN_LSB     8
`define SSL_FB_MAIN_MSB     20
`define SSL_FB_GAIN         21
`define SSL_FB_DIV2         22
`define SSL_FB_DIV2_SEL     23
// reference_divider_word fields
`define SSL_REF_DIV_LSB     2
`define SSL_REF_DIV_MSB     15
`define SSL_REF_ABP_LSB     16
`define SSL_REF_ABP_MSB     17
`define SSL_REF_LOCK_PREC   18
`define SSL_REF_TEST        19
`define SSL_REF_BSC_LSB     20
`define SSL_REF_BSC_MSB     21
// lock detect: good reference cycles needed
`define SSL_LOCK_CYC_FINE   3'd5
`define SSL_LOCK_CYC_COARSE 3'd3
// prescaler moduli selected by the control word
`define SSL_PRESC_P0        6'd8
`define SSL_PRESC_P1        6'd16
`define SSL_PRESC_P2        6'd32

`endif

// file: include/ssl_pkg.sv
// types shared by the serial latch block
package ssl_pkg;

  // destination latch chosen by the two address bits
  typedef enum logic [1:0] {
    SSL_TGT_CONTROL   = 2'b00,
    SSL_TGT_REFERENCE = 2'b01,
    SSL_TGT_FEEDBACK  = 2'b10,
    SSL_TGT_TEST      = 2'b11
  } ssl_target_type;

  // sources for the multiplexed output pin
  typedef enum logic [2:0] {
    SSL_MUX_LOW     = 3'b000,
    SSL_MUX_LOCK    = 3'b001,
    SSL_MUX_FBDIV   = 3'b010,
    SSL_MUX_HIGH    = 3'b011,
    SSL_MUX_REFDIV  = 3'b100,
    SSL_MUX_BSCLK   = 3'b101,
    SSL_MUX_SDATA   = 3'b110,
    SSL_MUX_NLOCK   = 3'b111
  } ssl_outsel_type;

endpackage

// file: tb/ssl_host_model.sv
// host side model of the three-wire write port
`timescale 1ns/10ps
`default_nettype none

module ssl_host_model (
  // clock
  input  wire logic i_mclk,
  // three-wire port
  output var logic  o_sclk,
  output var logic  o_sdata,
  output var logic  o_latch_enable
);
  // ==========================================================
  // idle levels: serial clock stands low outside frames
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_latch_enable = 1'b0;
  end

  // ==========================================================
  // shift n bits msb first, then pulse latch enable
  // levels held 2 cycles each so the sampled port sees every edge
  task automatic write_bits(input logic [27:0] w, input int n);
    logic [27:0] v;
    v = w;
    if (v[1:0] == 2'b10) v[7] = 1'b0;
    if (v[1:0] == 2'b01) v[23:22] = 2'b00;
    if (v[1:0] == 2'b01) v[19] = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata = v[i];
      o_sclk = 1'b0;
      repeat (2) @(negedge i_mclk);
      o_sclk = 1'b1;
      repeat (2) @(negedge i_mclk);
    end
    o_sclk = 1'b0;
    o_sdata = ~v[0]; // released data line does not keep its last value
    repeat (2) @(negedge i_mclk);
    o_latch_enable = 1'b1;
    repeat (2) @(negedge i_mclk);
    o_latch_enable = 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask
endmodule

`default_nettype wire

// file: tb/ssl_serial_latch_sva.sv
// port level assertions for the serial latch block
`timescale 1ns/10ps
`default_nettype none

module ssl_serial_latch_sva #(
  parameter int unsigned WORD_BITS = 24
) (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_srst,
  // port inputs
  input wire logic       i_latch_enable,
  input wire logic       i_ref_tick,
  input wire logic       i_fb_tick,
  input wire logic       i_phase_ok,
  // latched fields
  input wire logic [2:0] o_pump_current,
  input wire logic       o_pump_hiz,
  input wire logic       o_detector_polarity,
  input wire logic [1:0] o_core_level,
  input wire logic [1:0] o_rf_level,
  input wire logic [1:0] o_antibacklash,
  input wire logic [1:0] o_power_down,
  input wire logic       o_out_div2,
  input wire logic       o_presc_from_div2,
  input wire logic       o_test_mode_active,
  // divider and lock outputs
  input wire logic       o_rf_enable,
  input wire logic       o_ref_div_pulse,
  input wire logic       o_fb_div_pulse,
  input wire logic       o_bsel_clk_pulse,
  input wire logic       o_lock
);
  // ==========================================================
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  // ==========================================================
  // divider pulses only follow their cause one cycle earlier
  a_ref_after_tick: assert property (o_ref_div_pulse |-> $past(i_ref_tick))
    else $error("reference pulse without a tick");
  a_fb_after_tick: assert property (o_fb_div_pulse |-> $past(i_fb_tick))
    else $error("feedback pulse without a tick");
  a_bsel_after_ref: assert property (o_bsel_clk_pulse |-> $past(o_ref_div_pulse))
    else $error("band clock pulse without reference pulse");
  // lock rises only at reference pulses and clears after a bad one
  a_lock_rise_ref: assert property ($rose(o_lock) |-> $past(o_ref_div_pulse))
    else $error("lock rose away from a reference pulse");
  a_lock_clear_bad: assert property (o_ref_div_pulse && !i_phase_ok |=> !o_lock)
    else $error("lock kept after a bad phase cycle");
  // a locked loop never mutes the outputs
  a_lock_rf_on: assert property (o_lock |-> o_rf_enable)
    else $error("rf muted while locked");
  // latched fields move only after a latch enable rise
  a_fields_hold: assert property (!$rose(i_latch_enable) |=> $stable({o_pump_hiz,
    o_detector_polarity, o_core_level, o_rf_level, o_antibacklash, o_power_down,
    o_out_div2, o_presc_from_div2, o_test_mode_active}))
    else $error("latched field changed without commit");
  a_current_hold: assert property (!$rose(i_latch_enable) |=> $stable(o_pump_current))
    else $error("pump current changed without commit");

  // ==========================================================
  // main scenarios reached
  c_lock: cover property ($rose(o_lock));
  c_fb: cover property (o_fb_div_pulse);
  c_bsel: cover property (o_bsel_clk_pulse);
endmodule

`default_nettype wire

// file: tb/tb_synth_serial_latch_config.sv
// self-checking bench for the serial latch block
`timescale 1ns/10ps
`default_nettype none

module tb_synth_serial_latch_config;
  // ==========================================================
  // signals, names match the design ports
  logic       i_mclk, i_srst, i_sclk, i_sdata, i_latch_enable;
  logic       i_ref_tick, i_fb_tick, i_phase_ok;
  logic [2:0] o_pump_current;
  logic [1:0] o_core_level, o_rf_level, o_antibacklash, o_power_down;
  logic       o_pump_hiz, o_detector_polarity, o_rf_enable, o_out_div2, o_presc_from_div2;
  logic       o_test_mode_active, o_ref_div_pulse, o_fb_div_pulse, o_bsel_clk_pulse;
  logic       o_lock, o_muxed_output_pin;
  int         errors, checks, n_ref, n_fb, n_bs;
  localparam logic [7:0] MUX_EXP = 8'h88; // unlocked, no ticks: high and not-lock give 1

  ssl_serial_latch dut (.*);
  ssl_host_model host (.i_mclk(i_mclk), .o_sclk(i_sclk), .o_sdata(i_sdata),
    .o_latch_enable(i_latch_enable));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // count divider pulses mid-cycle, away from the edge that launches them
  always @(negedge i_mclk) begin
    if (o_ref_div_pulse === 1'b1) n_ref++;
    if (o_fb_div_pulse === 1'b1) n_fb++;
    if (o_bsel_clk_pulse === 1'b1) n_bs++;
  end

  // ==========================================================
  // helpers
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  // reference word: r=2, band clock code 01, test bit asked but dropped by host
  function automatic logic [23:0] refw(input logic p, input logic [1:0] ab);
    refw = 24'h18_0009 | {5'h00, p, ab, 16'h0000};
  endfunction

  // control word: mute on, p=8, fixed levels and currents
  function automatic logic [23:0] ctlw(input logic [2:0] s, input logic g, input logic r);
    ctlw = 24'h07_6B04 | {13'h0000, g, 2'b00, s, r, 4'h0};
  endfunction

  // n back to back reference and feedback ticks
  task automatic tick(input int n);
    n_ref = 0;
    n_fb = 0;
    n_bs = 0;
    repeat (n) begin
      @(negedge i_mclk);
      i_ref_tick = 1'b1;
      i_fb_tick = 1'b1;
    end
    @(negedge i_mclk);
    i_ref_tick = 1'b0;
    i_fb_tick = 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // hang guard
  initial begin
    repeat (100000) @(posedge i_mclk);
    errors++;
    final_report;
  end

  initial begin
    i_srst = 1'b1;
    i_ref_tick = 1'b0;
    i_fb_tick = 1'b0;
    i_phase_ok = 1'b0;
    repeat (20) @(negedge i_mclk);
    i_srst = 1'b0;
    check("rf_enable", 1, o_rf_enable);
    done("reset");
    host.write_bits({4'h0, refw(1'b1, 2'b10)}, 24);
    check("antibacklash", 2, o_antibacklash);
    check("test_mode", 0, o_test_mode_active);
    host.write_bits({4'h0, ctlw(3'd3, 1'b0, 1'b0)}, 24);
    check("core_level", 1, o_core_level);
    check("rf_level", 2, o_rf_level);
    check("polarity", 1, o_detector_polarity);
    check("pump_hiz", 1, o_pump_hiz);
    check("pump_low", 5, o_pump_current);
    check("rf_muted", 0, o_rf_enable);
    host.write_bits({4'h0, 24'hE0_038E}, 24);
    check("out_div2", 1, o_out_div2);
    check("presc_div2", 1, o_presc_from_div2);
    check("pump_high", 3, o_pump_current);
    for (int s = 0; s < 8; s++) begin
      host.write_bits({4'h0, ctlw(s[2:0], 1'b0, 1'b0)}, 24);
      check("muxed_pin", {15'h0000, MUX_EXP[s]}, o_muxed_output_pin);
    end
    check("gain_latest", 5, o_pump_current);
    done("latch decode");
    tick(56);
    check("fb_pulses", 3, n_fb);
    check("ref_pulses", 28, n_ref);
    check("bsel_pulses", 14, n_bs);
    done("dividers");
    i_phase_ok = 1'b1;
    tick(8);
    check("lock_early", 0, o_lock);
    tick(2);
    check("lock_five", 1, o_lock);
    check("rf_unmuted", 1, o_rf_enable);
    i_phase_ok = 1'b0;
    tick(2);
    check("lock_lost", 0, o_lock);
    host.write_bits({4'hF, refw(1'b0, 2'b11)}, 28);
    check("last_24_bits", 3, o_antibacklash);
    i_phase_ok = 1'b1;
    tick(4);
    check("lock_early3", 0, o_lock);
    tick(2);
    check("lock_three", 1, o_lock);
    done("lock detect");
    host.write_bits({4'h0, 24'hFF_FFFF}, 24);
    check("test_ignored", 3, o_antibacklash);
    check("test_no_hiz", 1, o_pump_hiz);
    host.write_bits({4'h0, ctlw(3'd0, 1'b0, 1'b1) | 24'h30_0000}, 24);
    check("power_down", 3, o_power_down);
    check("lock_held", 0, o_lock);
    tick(6);
    check("ref_held", 0, n_ref);
    check("fb_held", 0, n_fb);
    // prescaler 16: ratio 16 * 3 + 3 = 51, so 56 ticks give two pulses
    host.write_bits({4'h0, ctlw(3'd0, 1'b0, 1'b0) | 24'h40_0000}, 24);
    tick(56);
    check("fb_pulses_p16", 2, n_fb);
    done("test latch and counter reset");
    final_report;
  end
endmodule

bind ssl_serial_latch ssl_serial_latch_sva #(.WORD_BITS(WORD_BITS)) u_sva (.*);

`default_nettype wire
